// *** hdl/hub_cfg_pkg.sv ***
// Constants for the hub device configuration register block.
// Assumes a single 100 MHz clock domain and a byte-wide register port.
package hub_cfg_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] DEVICE_CONFIG_OFS = 8'h05;
  // ==========================================================
  // Field positions
  localparam int STR_OVR_BIT = 7;
  localparam int SER_OVR_BIT = 6;
  localparam int LPM_INH_BIT = 5;
  localparam int RSVD_ONE_BIT = 4;
  localparam int GROUP_BIT = 3;
  localparam int REPORT_BIT = 2;
  localparam int RSVD_RW_BIT = 1;
  localparam int RSVD_ZERO_BIT = 0;
  // ==========================================================
  // Reset and fixed values
  localparam logic [7:0] DEVICE_CONFIG_RST = 8'h10;
  localparam logic [7:0] WRITABLE_MASK = 8'hEE;
  localparam logic NUM_PORTS_ONE = 1'h1;
  localparam int NUM_PORTS = 4;
  // Synchroniser settle count before the straps are captured
  localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage

// *** hdl/cfg_wr_if.sv ***
// Write carrier between the register front end and the bit store.
// Assumes both ends share clk_i.
`timescale 1ns/100ps
`default_nettype none
interface cfg_wr_if;
  logic we;
  logic [7:0] wdata;
  logic [7:0] value;
  modport src (output we, output wdata, input value);
  modport dst (input we, input wdata, output value);
endinterface
`default_nettype wire

// *** hdl/cfg_bit_store.sv ***
// Masked byte store for the configuration register.
// Assumes strap values arrive already synchronised.
`timescale 1ns/100ps
`default_nettype none
module cfg_bit_store (
  input wire logic clk_i,            // System clock
  input wire logic rstn_i,           // Async reset, active low
  input wire logic strap_load_i,     // One pulse after reset release
  input wire logic strap_group_i,    // Synchronised grouping strap
  input wire logic strap_report_i,   // Synchronised report strap
  cfg_wr_if.dst wr                   // Write port
);
  // ==========================================================
  // Storage
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  logic [7:0] merged;

  // Writes only touch writable bits; fixed bits forced
  assign merged = (wr.wdata & hub_cfg_pkg::WRITABLE_MASK) |
    (hub_cfg_pkg::DEVICE_CONFIG_RST & ~hub_cfg_pkg::WRITABLE_MASK);

  // Strap capture first, later writes win afterwards
  always_comb begin
    value_nxt = value_r;
    if (strap_load_i) begin
      value_nxt[hub_cfg_pkg::GROUP_BIT] = strap_group_i;
      value_nxt[hub_cfg_pkg::REPORT_BIT] = strap_report_i;
    end
    if (wr.we) begin
      value_nxt = merged;
    end
  end

  // Reset clears override enables and inhibit bit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_r <= hub_cfg_pkg::DEVICE_CONFIG_RST;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign wr.value = value_r;

  // Fixed bits never change
  property p_fixed_bits;
    @(posedge clk_i) disable iff (!rstn_i)
      value_r[hub_cfg_pkg::RSVD_ONE_BIT] && !value_r[hub_cfg_pkg::RSVD_ZERO_BIT];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("reserved bits corrupted");
endmodule
`default_nettype wire

// *** hdl/hub_device_config_register.sv ***
// Device configuration register of a four-port hub, with its effects.
// Assumes config writes come from the EEPROM loader or SMBus slave
// already on clk_i; straps and link PM events arrive as noted.
`timescale 1ns/100ps
`default_nettype none
module hub_device_config_register (
  input wire logic clk_i,                 // 100 MHz clock
  input wire logic rstn_i,                // Async reset, active low
  input wire logic cfg_wr_i,              // Config write strobe
  input wire logic [7:0] cfg_addr_i,      // Config register offset
  input wire logic [7:0] cfg_wdata_i,     // Config write data
  input wire logic i2c_mode_i,            // EEPROM source selected
  input wire logic smbus_mode_i,          // SMBus source selected
  input wire logic grouping_strap_pin_i,  // Strap, async
  input wire logic report_strap_pin_i,    // Strap, async
  input wire logic forced_link_pm_accept_i, // Forced accept LMP seen/sent
  input wire logic upstream_disconnect_i, // Upstream port disconnected
  input wire logic [3:0] port_power_req_i,  // Per-port power requests
  input wire logic [3:0] port_power_status_i, // Per-port switch status
  output logic [7:0] cfg_rdata_o,         // Read data
  output logic string_write_enable_o,     // String regs writable
  output logic serial_write_enable_o,     // Serial regs writable
  output logic u1u2_allowed_o,            // Link may use U1/U2
  output logic [3:0] port_power_ctl_outputs_o, // Port power controls
  output logic [3:0] power_status_report_o // Reported switch status
);
  // ==========================================================
  // Strap synchronisers
  logic grp_s1_r;
  logic grp_s2_r;
  logic rep_s1_r;
  logic rep_s2_r;
  logic strap_done_r;
  logic strap_load;

  // Two flops before any logic reads a pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      grp_s1_r <= 1'h0;
      grp_s2_r <= 1'h0;
      rep_s1_r <= 1'h0;
      rep_s2_r <= 1'h0;
    end else begin
      grp_s1_r <= grouping_strap_pin_i;
      grp_s2_r <= grp_s1_r;
      rep_s1_r <= report_strap_pin_i;
      rep_s2_r <= rep_s1_r;
    end
  end

  // Capture waits two edges so the synchroniser holds the pin value
  logic [1:0] strap_wait_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'h0;
    end else begin
      if (strap_wait_r != hub_cfg_pkg::STRAP_WAIT) begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end
      if (strap_load) begin
        strap_done_r <= 1'h1;
      end
    end
  end
  assign strap_load = (strap_wait_r == hub_cfg_pkg::STRAP_WAIT) &&
    !strap_done_r;

  // ==========================================================
  // Register access
  logic hit;
  logic src_ok;
  logic [7:0] cfg;
  assign hit = (cfg_addr_i == hub_cfg_pkg::DEVICE_CONFIG_OFS);
  // Only the EEPROM loader or SMBus host may write
  assign src_ok = i2c_mode_i || smbus_mode_i;

  cfg_wr_if wr_bus ();
  assign wr_bus.we = cfg_wr_i && hit && src_ok && strap_done_r;
  assign wr_bus.wdata = cfg_wdata_i;
  assign cfg = wr_bus.value;

  cfg_bit_store u_store (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .strap_load_i(strap_load),
    .strap_group_i(grp_s2_r),
    .strap_report_i(rep_s2_r),
    .wr(wr_bus)
  );

  // ==========================================================
  // Forced link PM accept latch
  logic flpm_seen_r;
  logic flpm_nxt;
  // Disconnect clears; a coincident accept still wins
  assign flpm_nxt = forced_link_pm_accept_i ? 1'h1 :
    (upstream_disconnect_i ? 1'h0 : flpm_seen_r);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flpm_seen_r <= 1'h0;
    end else begin
      flpm_seen_r <= flpm_nxt;
    end
  end

  // ==========================================================
  // Decoded effects
  logic inhibit;
  logic grouped;
  logic rep_dis;
  logic u1u2_nxt;
  logic [3:0] pwr_nxt;
  logic [3:0] rpt_nxt;
  assign inhibit = cfg[hub_cfg_pkg::LPM_INH_BIT];
  assign grouped = cfg[hub_cfg_pkg::GROUP_BIT];
  assign rep_dis = cfg[hub_cfg_pkg::REPORT_BIT];
  assign u1u2_nxt = !inhibit || flpm_nxt;
  // Grouped power rides the first output only while reporting is on; others held off
  assign pwr_nxt = (grouped && !rep_dis) ? {3'h0, port_power_req_i[0]} :
    port_power_req_i;
  // Reporting off hides switch status
  assign rpt_nxt = rep_dis ? 4'h0 : port_power_status_i;

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_rdata_o <= hub_cfg_pkg::DEVICE_CONFIG_RST;
      string_write_enable_o <= 1'h0;
      serial_write_enable_o <= 1'h0;
      u1u2_allowed_o <= 1'h1;
      port_power_ctl_outputs_o <= 4'h0;
      power_status_report_o <= 4'h0;
    end else begin
      cfg_rdata_o <= hit ? cfg : 8'h00;
      string_write_enable_o <= cfg[hub_cfg_pkg::STR_OVR_BIT];
      serial_write_enable_o <= cfg[hub_cfg_pkg::SER_OVR_BIT];
      u1u2_allowed_o <= u1u2_nxt;
      port_power_ctl_outputs_o <= pwr_nxt;
      power_status_report_o <= rpt_nxt;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_inhibit_no_flpm;
    inhibit && !flpm_nxt;
  endsequence
  property p_inhibit_blocks;
    @(posedge clk_i) disable iff (!rstn_i) s_inhibit_no_flpm |=> !u1u2_allowed_o;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("U1/U2 allowed while inhibited");

  property p_no_inhibit;
    @(posedge clk_i) disable iff (!rstn_i) !inhibit |=> u1u2_allowed_o;
  endproperty
  a_no_inhibit: assert property (p_no_inhibit) else $error("U1/U2 blocked without inhibit");

  property p_flpm_holds;
    @(posedge clk_i) disable iff (!rstn_i)
      forced_link_pm_accept_i ##1 (!upstream_disconnect_i)[*2] |-> u1u2_allowed_o;
  endproperty
  a_flpm_holds: assert property (p_flpm_holds) else $error("forced accept not honoured");

  property p_grouped;
    @(posedge clk_i) disable iff (!rstn_i)
      grouped && !rep_dis |=> port_power_ctl_outputs_o[3:1] == 3'h0;
  endproperty
  a_grouped: assert property (p_grouped) else $error("grouped power on extra ports");

  property p_individual;
    @(posedge clk_i) disable iff (!rstn_i)
      !grouped && !rep_dis |=> port_power_ctl_outputs_o == $past(port_power_req_i);
  endproperty
  a_individual: assert property (p_individual) else $error("per-port power wrong");

  property p_report;
    @(posedge clk_i) disable iff (!rstn_i) rep_dis |=> power_status_report_o == 4'h0;
  endproperty
  a_report: assert property (p_report) else $error("status reported while disabled");

  property p_string_en;
    @(posedge clk_i) disable iff (!rstn_i)
      string_write_enable_o == $past(cfg[hub_cfg_pkg::STR_OVR_BIT]);
  endproperty
  a_string_en: assert property (p_string_en) else $error("string enable mismatch");

  property p_serial_en;
    @(posedge clk_i) disable iff (!rstn_i)
      serial_write_enable_o == $past(cfg[hub_cfg_pkg::SER_OVR_BIT]);
  endproperty
  a_serial_en: assert property (p_serial_en) else $error("serial enable mismatch");

  property p_strap_cap;
    @(posedge clk_i) disable iff (!rstn_i)
      strap_load && !wr_bus.we |=> cfg[hub_cfg_pkg::GROUP_BIT] == $past(grp_s2_r) &&
        cfg[hub_cfg_pkg::REPORT_BIT] == $past(rep_s2_r);
  endproperty
  a_strap_cap: assert property (p_strap_cap) else $error("strap not captured");

  property p_read_fixed;
    @(posedge clk_i) disable iff (!rstn_i)
      hit |=> cfg_rdata_o[hub_cfg_pkg::RSVD_ONE_BIT] && !cfg_rdata_o[hub_cfg_pkg::RSVD_ZERO_BIT];
  endproperty
  a_read_fixed: assert property (p_read_fixed) else $error("reserved read wrong");

  // ==========================================================
  // Write, read, capture and effect checks
  sequence s_write_taken;
    wr_bus.we;
  endsequence
  sequence s_no_update;
    !wr_bus.we && !strap_load;
  endsequence
  sequence s_capture_done;
    strap_done_r && !strap_load;
  endsequence

  // A taken write lands on every writable bit
  property p_write_lands;
    @(posedge clk_i) disable iff (!rstn_i)
      s_write_taken |=> (cfg & hub_cfg_pkg::WRITABLE_MASK) ==
        ($past(cfg_wdata_i) & hub_cfg_pkg::WRITABLE_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write lost");

  // Only a capture or a write may move the register
  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      s_no_update |=> cfg == $past(cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved unprompted");

  // Off-address strobes never reach the store
  property p_addr_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      !hit |-> !wr_bus.we;
  endproperty
  a_addr_gate: assert property (p_addr_gate) else $error("off-address write");

  // With no source selected, writes are refused
  property p_mode_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      !src_ok |-> !wr_bus.we;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("sourceless write");

  // A write may not race the strap capture
  property p_no_early;
    @(posedge clk_i) disable iff (!rstn_i)
      !strap_done_r |-> !wr_bus.we;
  endproperty
  a_no_early: assert property (p_no_early) else $error("early write");

  // Capture fires once per reset release
  property p_strap_once;
    @(posedge clk_i) disable iff (!rstn_i)
      strap_load |=> s_capture_done;
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("capture repeated");

  // Read data trails the register by one edge
  property p_read_value;
    @(posedge clk_i) disable iff (!rstn_i)
      hit |=> cfg_rdata_o == $past(cfg);
  endproperty
  a_read_value: assert property (p_read_value) else $error("read value wrong");

  // Reads elsewhere return zero
  property p_read_off;
    @(posedge clk_i) disable iff (!rstn_i)
      !hit |=> cfg_rdata_o == 8'h00;
  endproperty
  a_read_off: assert property (p_read_off) else $error("off-address read");

  // Enabled reporting passes status straight through
  property p_report_on;
    @(posedge clk_i) disable iff (!rstn_i)
      !rep_dis |=> power_status_report_o == $past(port_power_status_i);
  endproperty
  a_report_on: assert property (p_report_on) else $error("status not reported");

  // Grouped switching still follows the first request
  property p_grouped_first;
    @(posedge clk_i) disable iff (!rstn_i)
      grouped && !rep_dis |=> port_power_ctl_outputs_o[0] == $past(port_power_req_i[0]);
  endproperty
  a_grouped_first: assert property (p_grouped_first) else $error("group port0 wrong");

  // Forced accept reopens U1/U2 at the next edge
  property p_flpm_set;
    @(posedge clk_i) disable iff (!rstn_i)
      forced_link_pm_accept_i |=> u1u2_allowed_o;
  endproperty
  a_flpm_set: assert property (p_flpm_set) else $error("forced accept ignored");
endmodule
`default_nettype wire

// *** verif/cfg_source.sv ***
// Model of the config source (EEPROM loader or SMBus host) on the write port.
// Assumes the bench raises go_i just after a clock edge for one cycle.
`timescale 1ns/100ps
`default_nettype none
module cfg_source (
  input wire logic clk_i,        // System clock
  input wire logic go_i,         // Issue one write
  input wire logic [7:0] a_i,    // Offset to present
  input wire logic [7:0] d_i,    // Byte to write
  output logic wr_o,             // Write strobe
  output logic [7:0] addr_o,     // Offset
  output logic [7:0] wdata_o     // Write data
);
  // ==========================================
  // Drive on the edge; idle data is the inverse, so a stray take shows
  always @(posedge clk_i) begin
    wr_o <= go_i;
    addr_o <= a_i;
    wdata_o <= go_i ? (d_i & 8'hFD) : ~(d_i & 8'hFD);  // Bit 1 left at default
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the device configuration register.
// Assumes cfg_source stands in for the EEPROM loader and SMBus host.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i, rstn_i, go, i2c, smb, gs, rs, flpm, disc, wr, swe, nwe, u12;
  logic [7:0] a, d, rdata, addr, wdata;
  logic [3:0] req, sts, pwr, rep;
  int mismatches, comparisons;
  cfg_source src (.clk_i(clk_i), .go_i(go), .a_i(a), .d_i(d), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata));
  hub_device_config_register dut (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .i2c_mode_i(i2c), .smbus_mode_i(smb),
    .grouping_strap_pin_i(gs), .report_strap_pin_i(rs),
    .forced_link_pm_accept_i(flpm), .upstream_disconnect_i(disc),
    .port_power_req_i(req), .port_power_status_i(sts), .cfg_rdata_o(rdata),
    .string_write_enable_o(swe), .serial_write_enable_o(nwe),
    .u1u2_allowed_o(u12), .port_power_ctl_outputs_o(pwr),
    .power_status_report_o(rep));
  // ==========================================
  // Clock, 10 ns period
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Straps held well past capture, as the store needs
  task automatic do_reset(input logic g, input logic r);
    rstn_i = 1'h0;
    gs = g;
    rs = r;
    cyc(16);
    chk(rdata, 8'h10);
    chk({5'h00, swe, nwe, u12}, 8'h01);
    rstn_i = 1'h1;
    cyc(6);
  endtask
  task automatic write(input logic [7:0] ad, input logic [7:0] dt);
    a = ad;
    d = dt;
    go = 1'h1;
    cyc(1);
    go = 1'h0;
    a = 8'h05;
    cyc(3);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    do_reset(1'b1, 1'b0);
    chk(rdata, 8'h18);
    do_reset(1'b0, 1'b1);
    chk(rdata, 8'h14);
    $display("done reset");
  endtask
  task automatic t_power;
    req = 4'hB;
    sts = 4'h6;
    cyc(2);
    chk({4'h0, rep}, 8'h00);
    write(8'h05, 8'h08);
    chk({4'h0, pwr}, 8'h01);
    chk({4'h0, rep}, 8'h06);
    write(8'h05, 8'h00);
    chk({4'h0, pwr}, 8'h0B);
    chk({7'h00, u12}, 8'h01);
    $display("done power");
  endtask
  task automatic t_bits;
    write(8'h05, 8'hFF);
    chk(rdata, 8'hFC);
    chk({5'h00, swe, nwe, u12}, 8'h06);
    flpm = 1'h1;
    cyc(1);
    flpm = 1'h0;
    cyc(1);
    chk({7'h00, u12}, 8'h01);
    cyc(4);
    chk({7'h00, u12}, 8'h01);
    disc = 1'h1;
    cyc(1);
    disc = 1'h0;
    cyc(1);
    chk({7'h00, u12}, 8'h00);
    flpm = 1'h1;
    disc = 1'h1;
    cyc(2);
    chk({7'h00, u12}, 8'h01);
    flpm = 1'h0;
    cyc(2);
    chk({7'h00, u12}, 8'h00);
    disc = 1'h0;
    $display("done bits");
  endtask
  task automatic t_source;
    i2c = 1'h0;
    smb = 1'h0;
    write(8'h05, 8'h00);
    chk(rdata, 8'hFC);
    smb = 1'h1;
    write(8'h06, 8'h00);
    chk(rdata, 8'hFC);
    a = 8'h06;
    cyc(2);
    chk(rdata, 8'h00);
    a = 8'h05;
    cyc(2);
    chk(rdata, 8'hFC);
    write(8'h05, 8'h20);
    chk(rdata, 8'h30);
    smb = 1'h0;
    i2c = 1'h1;
    write(8'h05, 8'h04);
    chk(rdata, 8'h14);
    $display("done source");
  endtask
  // ==========================================
  // Verdict, single exit point
  task automatic conclude;
    $display("checks %0d bad %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog sized well above the ninety or so cycles needed
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    {rstn_i, go, smb, gs, rs, flpm, disc} = 7'h00;
    i2c = 1'h1;
    a = 8'h05;
    d = 8'h00;
    req = 4'h0;
    sts = 4'h0;
    mismatches = 0;
    comparisons = 0;
    t_reset();
    t_power();
    t_bits();
    t_source();
    conclude();
  end
endmodule
`default_nettype wire
